/* File: dv/tb_top.sv */
// Self-checking testbench of the offset trim register bank.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import oft_pkg::*;

  logic                clk;
  logic                rst_b;
  logic                wr;
  logic                rd;
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   wdata;
  logic [DATA_W-1:0]   rdata;
  oft_trim_set_s       factory;
  logic [2:0]          sel;
  oft_core_trim_s      trim0;
  oft_core_trim_s      trim1;
  oft_core_trim_s      trim2;
  logic [REG_W-1:0]    mdl [NUM_REGS];
  logic [ADDR_W-1:0]   base [NUM_REGS];
  logic [REG_W-1:0]    new_val [NUM_REGS];
  int                  n_errors;
  int                  checks;
  int                  cycles;

  oft_offset_trim_regs i_dut (
    .CLK_IN             (clk),
    .RST_B_IN           (rst_b),
    .REG_ADDR_IN        (addr),
    .REG_WDATA_IN       (wdata),
    .REG_WR_IN          (wr),
    .REG_RD_IN          (rd),
    .REG_RDATA_OUT      (rdata),
    .FACTORY_TRIM_IN    (factory),
    .CORE_ON_INPUT_B_IN (sel),
    .CORE0_TRIM_OUT     (trim0),
    .CORE1_TRIM_OUT     (trim1),
    .CORE2_TRIM_OUT     (trim2)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic final_report();
    if (n_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // The strobe is lowered at the edge that takes it, so each call leaves a gap cycle.
  task automatic wr_byte(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_byte(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    chk({8'h00, rdata}, {8'h00, e});
    @(negedge clk);
    chk({8'h00, rdata}, 16'h0000);
  endtask

  task automatic rd_reg(input int i);
    rd_byte(base[i], mdl[i][7:0]);
    rd_byte(base[i] + 12'h001, mdl[i][15:8]);
  endtask

  // A hang is cut short well after the fewer than two hundred cycles the sequence needs.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      final_report();
    end
  end

  initial begin
    rst_b      = 1'b0;
    wr         = 1'b0;
    rd         = 1'b0;
    addr       = 12'h000;
    wdata      = 8'h00;
    sel        = 3'h0;
    factory    = '{12'hA5C, 12'h3E1, 12'h7B2, 12'hC4D};
    base       = '{ADDR_CORE0_INPUT_B, ADDR_CORE1_INPUT_A, ADDR_CORE1_INPUT_B, ADDR_CORE2_INPUT_A};
    new_val    = '{16'hF123, 16'h5ABC, 16'h8FFF, 16'h0000};
    mdl        = '{{4'h0, 12'hA5C}, {4'h0, 12'h3E1}, {4'h0, 12'h7B2}, {4'h0, 12'hC4D}};
    n_errors   = 0;
    checks     = 0;
    cycles     = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    // No calibration engine is modelled, so every access here is allowed
    for (int i = 0; i < NUM_REGS; i++) rd_reg(i);
    wr_byte(12'h094, 8'hFF);
    rd_byte(12'h094, 8'h00);
    rd_byte(12'h08A, 8'h00);
    // Low byte alone first: the high byte must keep its factory value.
    wr_byte(base[1], new_val[1][7:0]);
    mdl[1][7:0] = new_val[1][7:0];
    rd_reg(1);
    for (int i = 0; i < NUM_REGS; i++) begin
      wr_byte(base[i], new_val[i][7:0]);
      wr_byte(base[i] + 12'h001, new_val[i][15:8]);
      mdl[i] = new_val[i];
    end
    for (int i = 0; i < NUM_REGS; i++) rd_reg(i);
    for (int s = 0; s < 8; s++) begin
      @(posedge clk);
      sel <= s[2:0];
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk({3'h0, trim0}, s[0] ? {4'h1, mdl[0][11:0]} : 16'h0000);
      chk({3'h0, trim1}, {4'h1, s[1] ? mdl[2][11:0] : mdl[1][11:0]});
      chk({3'h0, trim2}, s[2] ? 16'h0000 : {4'h1, mdl[3][11:0]});
    end
    // A rewrite while core two samples input B must stay off its output and appear once input A is selected.
    wr_byte(base[3], 8'h5A);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({3'h0, trim2}, 16'h0000);
    @(posedge clk);
    sel <= 3'h0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({3'h0, trim2}, {4'h1, mdl[3][11:8], 8'h5A});
    // Write, read and write again with no idle cycle between the strobes.
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= base[0];
    wdata <= 8'h3C;
    @(posedge clk);
    wr    <= 1'b0;
    rd    <= 1'b1;
    @(posedge clk);
    rd    <= 1'b0;
    wr    <= 1'b1;
    wdata <= 8'hC3;
    @(negedge clk);
    chk({8'h00, rdata}, 16'h003C);
    @(posedge clk);
    wr    <= 1'b0;
    mdl[0][7:0] = 8'hC3;
    rd_reg(0);
    // A second reset brings the factory trim back; a write on the first edge after release is dropped.
    @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    wr    <= 1'b1;
    addr  <= base[2];
    wdata <= 8'h00;
    @(posedge clk);
    wr    <= 1'b0;
    mdl   = '{{4'h0, 12'hA5C}, {4'h0, 12'h3E1}, {4'h0, 12'h7B2}, {4'h0, 12'hC4D}};
    for (int i = 0; i < NUM_REGS; i++) rd_reg(i);
    chk({3'h0, trim1}, {4'h1, mdl[1][11:0]});
    chk({3'h0, trim2}, {4'h1, mdl[3][11:0]});
    final_report();
  end

endmodule

`default_nettype wire

/* File: hw/oft_offset_trim_regs.sv */
// Offset trim register bank for the three converter cores, with byte-wide register port.
//
// Chosen here: strobed register access.
`default_nettype none

// What this block does
// - Each register keeps an unsigned 12-bit trim in bits 11-0; bits 15-12 reserved.
// - Core zero input B trim is driven only while core zero samples input B.
// - Core one input A trim is driven only while core one samples input A.
// - Core one input B trim is driven only while core one samples input B.
// - Core two input A trim is driven only while core two samples input A.
// - From the second edge after reset release registers read factory trim and a write replaces it.
// - Core one input A register sits at bytes 0x08E and 0x08F.
// - Core one input B register sits at bytes 0x090 and 0x091.
// - Core two input A register sits at bytes 0x092 and 0x093.
module oft_offset_trim_regs (
  input  wire logic                            CLK_IN,
  input  wire logic                            RST_B_IN,
  input  wire logic [oft_pkg::ADDR_W-1:0]      REG_ADDR_IN,
  input  wire logic [oft_pkg::DATA_W-1:0]      REG_WDATA_IN,
  input  wire logic                            REG_WR_IN,
  input  wire logic                            REG_RD_IN,
  output logic      [oft_pkg::DATA_W-1:0]      REG_RDATA_OUT,
  input  wire oft_pkg::oft_trim_set_s          FACTORY_TRIM_IN,
  input  wire logic [2:0]                      CORE_ON_INPUT_B_IN,
  output oft_pkg::oft_core_trim_s              CORE0_TRIM_OUT,
  output oft_pkg::oft_core_trim_s              CORE1_TRIM_OUT,
  output oft_pkg::oft_core_trim_s              CORE2_TRIM_OUT
);
  import oft_pkg::*;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  // Returns {hit, index} for a byte address; both bytes of a pair share an index.
  function automatic logic [IDX_W:0] decode_addr(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] base;
    base = {addr[ADDR_W-1:1], 1'b0};
    if (base == ADDR_CORE0_INPUT_B) begin
      decode_addr = {1'b1, IDX_CORE0_INPUT_B};
    end else if (base == ADDR_CORE1_INPUT_A) begin
      decode_addr = {1'b1, IDX_CORE1_INPUT_A};
    end else if (base == ADDR_CORE1_INPUT_B) begin
      decode_addr = {1'b1, IDX_CORE1_INPUT_B};
    end else if (base == ADDR_CORE2_INPUT_A) begin
      decode_addr = {1'b1, IDX_CORE2_INPUT_A};
    end else begin
      decode_addr = {1'b0, IDX_CORE0_INPUT_B};
    end
  endfunction

  logic [REG_W-1:0]  regs [NUM_REGS];
  logic              loaded;
  logic [DATA_W-1:0] rdata;
  oft_core_trim_s    core0_trim;
  oft_core_trim_s    core1_trim;
  oft_core_trim_s    core2_trim;

  wire logic [IDX_W:0]    dec       = decode_addr(REG_ADDR_IN);
  wire logic              hit       = dec[IDX_W];
  wire logic [IDX_W-1:0]  idx       = dec[IDX_W-1:0];
  wire logic              high_byte = REG_ADDR_IN[0];
  wire logic              wr_ok     = REG_WR_IN && hit && loaded;

  // The selected byte of the addressed register; unmapped addresses read zero.
  wire logic [DATA_W-1:0] read_byte =
    !hit      ? RDATA_RST :
    high_byte ? regs[idx][REG_W-1:DATA_W] :
                regs[idx][DATA_W-1:0];

  wire logic [REG_W-1:0] factory_word [NUM_REGS];
  assign factory_word[IDX_CORE0_INPUT_B] = {RESERVED_RST, FACTORY_TRIM_IN.core0_input_b};
  assign factory_word[IDX_CORE1_INPUT_A] = {RESERVED_RST, FACTORY_TRIM_IN.core1_input_a};
  assign factory_word[IDX_CORE1_INPUT_B] = {RESERVED_RST, FACTORY_TRIM_IN.core1_input_b};
  assign factory_word[IDX_CORE2_INPUT_A] = {RESERVED_RST, FACTORY_TRIM_IN.core2_input_a};

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------

  // The factory trim cannot be taken under the asynchronous reset, so it is loaded
  // on the first edge after release; a write in that cycle is dropped.
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      loaded <= 1'b0;
    end else begin
      loaded <= 1'b1;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= REG_RST;
      end
    end else if (!loaded) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= factory_word[i];
      end
    end else if (wr_ok && high_byte) begin
      regs[idx][REG_W-1:DATA_W] <= REG_WDATA_IN;
    end else if (wr_ok) begin
      regs[idx][DATA_W-1:0] <= REG_WDATA_IN;
    end
  end

  // Read data stands only in the cycle after the read strobe.
  // Idle cycles return zero, so a stale byte is never taken for a fresh answer.
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rdata <= RDATA_RST;
    end else begin
      rdata <= REG_RD_IN ? read_byte : RDATA_RST;
    end
  end

  assign REG_RDATA_OUT = rdata;

  // ----------------------------------------------------------------
  // Trim application to the cores
  // ----------------------------------------------------------------

  // Only the 12-bit trim field goes to a core; reserved bits steer nothing.
  wire logic [TRIM_W-1:0] trim_c0b = regs[IDX_CORE0_INPUT_B][TRIM_MSB:TRIM_LSB];
  wire logic [TRIM_W-1:0] trim_c1a = regs[IDX_CORE1_INPUT_A][TRIM_MSB:TRIM_LSB];
  wire logic [TRIM_W-1:0] trim_c1b = regs[IDX_CORE1_INPUT_B][TRIM_MSB:TRIM_LSB];
  wire logic [TRIM_W-1:0] trim_c2a = regs[IDX_CORE2_INPUT_A][TRIM_MSB:TRIM_LSB];

  // Core zero on input A and core two on input B take trims held elsewhere,
  // so this bank drops valid for them.
  wire oft_core_trim_s next_core0_trim =
    CORE_ON_INPUT_B_IN[0] ? oft_core_trim_s'{valid: 1'b1, value: trim_c0b} :
                            oft_core_trim_s'{valid: 1'b0, value: TRIM_RST};
  wire oft_core_trim_s next_core1_trim =
    CORE_ON_INPUT_B_IN[1] ? oft_core_trim_s'{valid: 1'b1, value: trim_c1b} :
                            oft_core_trim_s'{valid: 1'b1, value: trim_c1a};
  wire oft_core_trim_s next_core2_trim =
    !CORE_ON_INPUT_B_IN[2] ? oft_core_trim_s'{valid: 1'b1, value: trim_c2a} :
                             oft_core_trim_s'{valid: 1'b0, value: TRIM_RST};

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      core0_trim <= '{valid: 1'b0, value: TRIM_RST};
      core1_trim <= '{valid: 1'b0, value: TRIM_RST};
      core2_trim <= '{valid: 1'b0, value: TRIM_RST};
    end else begin
      core0_trim <= next_core0_trim;
      core1_trim <= next_core1_trim;
      core2_trim <= next_core2_trim;
    end
  end

  assign CORE0_TRIM_OUT = core0_trim;
  assign CORE1_TRIM_OUT = core1_trim;
  assign CORE2_TRIM_OUT = core2_trim;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);

  wire logic [ADDR_W-1:0] addr_base = {REG_ADDR_IN[ADDR_W-1:1], 1'b0};

  // ----------------------------------------------------------------
  // Register port checks
  // ----------------------------------------------------------------

  // Keyed on the rise of the load flag: the flag stays high after the load, so an antecedent
  // on the flag level would also fire after a write has replaced a factory word.
  a_factory_load_word: assert property (
    $rose(loaded) |-> (regs[IDX_CORE0_INPUT_B] == $past(factory_word[IDX_CORE0_INPUT_B]))
                   && (regs[IDX_CORE1_INPUT_A] == $past(factory_word[IDX_CORE1_INPUT_A]))
                   && (regs[IDX_CORE1_INPUT_B] == $past(factory_word[IDX_CORE1_INPUT_B]))
                   && (regs[IDX_CORE2_INPUT_A] == $past(factory_word[IDX_CORE2_INPUT_A])))
    else $error("Factory trim not loaded after reset release.");

  a_loaded_holds: assert property (
    loaded |=> loaded)
    else $error("Load flag fell without a reset.");

  // A write on the first edge after release loses to the factory load.
  a_first_write_dropped: assert property (
    REG_WR_IN && !loaded && RST_B_IN |=> regs[$past(idx)] == $past(factory_word[idx]))
    else $error("Write on the load edge was not dropped.");

  a_write_low_byte: assert property (
    wr_ok && !high_byte |=> regs[$past(idx)][DATA_W-1:0] == $past(REG_WDATA_IN))
    else $error("Low byte write did not land in bits 7-0.");

  a_write_high_byte: assert property (
    wr_ok && high_byte |=> regs[$past(idx)][REG_W-1:DATA_W] == $past(REG_WDATA_IN))
    else $error("High byte write did not land in bits 15-8.");

  // Bytes land on their own; the other half of the pair must not move.
  a_write_low_keeps_high: assert property (
    wr_ok && !high_byte |=> regs[$past(idx)][REG_W-1:DATA_W] == $past(regs[idx][REG_W-1:DATA_W]))
    else $error("Low byte write disturbed bits 15-8.");

  a_write_high_keeps_low: assert property (
    wr_ok && high_byte |=> regs[$past(idx)][DATA_W-1:0] == $past(regs[idx][DATA_W-1:0]))
    else $error("High byte write disturbed bits 7-0.");

  a_core1a_address: assert property (
    REG_RD_IN && addr_base == 12'h08E |=> REG_RDATA_OUT ==
      ($past(REG_ADDR_IN[0]) ? regs[IDX_CORE1_INPUT_A][15:8] : regs[IDX_CORE1_INPUT_A][7:0]))
    else $error("Core one input A register not at 0x08E.");

  a_core1b_address: assert property (
    REG_RD_IN && REG_ADDR_IN == 12'h090 |=> REG_RDATA_OUT == regs[IDX_CORE1_INPUT_B][7:0])
    else $error("Core one input B register not at 0x090.");

  a_core2a_address: assert property (
    REG_RD_IN && REG_ADDR_IN == 12'h093 |=> REG_RDATA_OUT == regs[IDX_CORE2_INPUT_A][15:8])
    else $error("Core two input A register not at 0x093.");

  a_core0b_address: assert property (
    REG_RD_IN && addr_base == 12'h08C |=> REG_RDATA_OUT ==
      ($past(REG_ADDR_IN[0]) ? regs[IDX_CORE0_INPUT_B][15:8] : regs[IDX_CORE0_INPUT_B][7:0]))
    else $error("Core zero input B register not at 0x08C.");

  a_core1b_high: assert property (
    REG_RD_IN && REG_ADDR_IN == 12'h091 |=> REG_RDATA_OUT == regs[IDX_CORE1_INPUT_B][15:8])
    else $error("Core one input B high byte not at 0x091.");

  a_core2a_low: assert property (
    REG_RD_IN && REG_ADDR_IN == 12'h092 |=> REG_RDATA_OUT == regs[IDX_CORE2_INPUT_A][7:0])
    else $error("Core two input A low byte not at 0x092.");

  a_unmapped_read: assert property (
    REG_RD_IN && !hit |=> REG_RDATA_OUT == RDATA_RST)
    else $error("Unmapped address returned data.");

  a_read_idle_zero: assert property (
    !REG_RD_IN |=> REG_RDATA_OUT == RDATA_RST)
    else $error("Read data shown without a read strobe.");

  // A stray write must leave every word alone, reserved bits included.
  a_unmapped_write: assert property (
    REG_WR_IN && !hit && loaded |=> regs[IDX_CORE0_INPUT_B] == $past(regs[IDX_CORE0_INPUT_B])
                                 && regs[IDX_CORE1_INPUT_A] == $past(regs[IDX_CORE1_INPUT_A])
                                 && regs[IDX_CORE1_INPUT_B] == $past(regs[IDX_CORE1_INPUT_B])
                                 && regs[IDX_CORE2_INPUT_A] == $past(regs[IDX_CORE2_INPUT_A]))
    else $error("Write to an unmapped address changed a register.");

  a_read_one_cycle: assert property (
    REG_RD_IN && hit ##1 !REG_RD_IN |=> REG_RDATA_OUT == RDATA_RST)
    else $error("Read data stood longer than one cycle.");

  // ----------------------------------------------------------------
  // Core trim checks
  // ----------------------------------------------------------------

  a_core0_b_only: assert property (
    CORE_ON_INPUT_B_IN[0] |=> CORE0_TRIM_OUT.valid && CORE0_TRIM_OUT.value == $past(trim_c0b))
    else $error("Core zero input B trim not applied.");

  a_core0_a_idle: assert property (
    !CORE_ON_INPUT_B_IN[0] |=> !CORE0_TRIM_OUT.valid && CORE0_TRIM_OUT.value == TRIM_RST)
    else $error("Core zero trim driven outside input B.");

  a_core1_a_sel: assert property (
    !CORE_ON_INPUT_B_IN[1] |=> CORE1_TRIM_OUT.value == $past(trim_c1a))
    else $error("Core one input A trim not applied.");

  a_core1_b_sel: assert property (
    CORE_ON_INPUT_B_IN[1] |=> CORE1_TRIM_OUT.value == $past(trim_c1b))
    else $error("Core one input B trim not applied.");

  a_core2_a_only: assert property (
    CORE_ON_INPUT_B_IN[2] |=> !CORE2_TRIM_OUT.valid && CORE2_TRIM_OUT.value == TRIM_RST)
    else $error("Core two trim driven outside input A.");

  a_trim_field_width: assert property (
    CORE2_TRIM_OUT.valid |-> CORE2_TRIM_OUT.value == $past(trim_c2a))
    else $error("Core two trim does not match bits 11-0.");

  // Core one takes a trim from this bank on either input once the load is done.
  a_core1_always_valid: assert property (
    loaded |-> CORE1_TRIM_OUT.valid)
    else $error("Core one trim dropped valid.");

  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------

  c_write_then_read: cover property (wr_ok ##1 REG_RD_IN && hit);
  c_core1_swap: cover property (!CORE_ON_INPUT_B_IN[1] ##1 CORE_ON_INPUT_B_IN[1]);
  c_unmapped_read: cover property (REG_RD_IN && !hit);
  c_back_to_back: cover property (REG_WR_IN ##1 REG_RD_IN ##1 REG_WR_IN);
  c_first_write_dropped: cover property (REG_WR_IN && !loaded && RST_B_IN);

endmodule

`default_nettype wire

/* File: hw/oft_pkg.sv */
// Package with register map, field layout and carrier types of the offset trim bank.
`default_nettype none

package oft_pkg;

  // ----------------------------------------------------------------
  // Register bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned REG_W  = 16;
  localparam int unsigned TRIM_W = 12;
  localparam int unsigned NUM_REGS = 4;
  localparam int unsigned IDX_W  = 2;

  // ----------------------------------------------------------------
  // Byte addresses of the low byte of each register pair
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CORE0_INPUT_B = 12'h08C;
  localparam logic [ADDR_W-1:0] ADDR_CORE1_INPUT_A = 12'h08E;
  localparam logic [ADDR_W-1:0] ADDR_CORE1_INPUT_B = 12'h090;
  localparam logic [ADDR_W-1:0] ADDR_CORE2_INPUT_A = 12'h092;

  // Storage index of each register.
  localparam logic [IDX_W-1:0] IDX_CORE0_INPUT_B = 2'h0;
  localparam logic [IDX_W-1:0] IDX_CORE1_INPUT_A = 2'h1;
  localparam logic [IDX_W-1:0] IDX_CORE1_INPUT_B = 2'h2;
  localparam logic [IDX_W-1:0] IDX_CORE2_INPUT_A = 2'h3;

  // ----------------------------------------------------------------
  // Field layout and values after reset
  // ----------------------------------------------------------------
  localparam int unsigned TRIM_LSB     = 0;
  localparam int unsigned TRIM_MSB     = 11;
  localparam logic [3:0]  RESERVED_RST = 4'h0;
  localparam logic [REG_W-1:0]  REG_RST   = 16'h0000;
  localparam logic [DATA_W-1:0] RDATA_RST = 8'h00;
  localparam logic [TRIM_W-1:0] TRIM_RST  = 12'h000;

  // Factory trim values, one per register.
  typedef struct packed {
    logic [TRIM_W-1:0] core0_input_b;
    logic [TRIM_W-1:0] core1_input_a;
    logic [TRIM_W-1:0] core1_input_b;
    logic [TRIM_W-1:0] core2_input_a;
  } oft_trim_set_s;

  // Trim handed to one converter core.
  typedef struct packed {
    logic              valid;
    logic [TRIM_W-1:0] value;
  } oft_core_trim_s;

endpackage

`default_nettype wire
